// ### verilog/sdc_regs.svh
// Purpose: Constants for the concurrent auto-precharge SDRAM core
// Assumes: 125 MHz core clock, command pins sampled on rising edge
// Notes:   Timing counts derive from nanosecond figures and clock rate
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// Clock and array timing
`define SDC_CLK_MHZ    125
`define SDC_TWR_NS     15
`define SDC_TRP_NS     20
// Least times round up to whole cycles
`define SDC_TWR_CYC    ((`SDC_TWR_NS * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_TRP_CYC    ((`SDC_TRP_NS * `SDC_CLK_MHZ + 999) / 1000)

// Address field positions
`define SDC_COL_LSB    0
`define SDC_COL_W      8
`define SDC_AP_BIT     10
`define SDC_CL_LSB     4
`define SDC_BL_LSB     0
`define SDC_WBS_BIT    9

// Mode register reset values and full-page burst code
`define SDC_CL_RST     3'h2
`define SDC_BL_RST     3'h0
`define SDC_BL_PAGE    3'h7

// Write buffer
`define SDC_FIFO_DEPTH 8
`define SDC_FIFO_W     28

`endif

// ### verilog/sdc_pkg.sv
// Purpose: Types shared by the SDRAM core files
// Assumes: Command code is {ras_n, cas_n, we_n}
// Notes:   Bank states are Gray coded around the precharge loop
`default_nettype none
package sdc_pkg;

  // Command encoding as seen on the pins
  typedef enum logic [2:0] {
    SDC_CMD_MRS = 3'h0,
    SDC_CMD_REF = 3'h1,
    SDC_CMD_PRE = 3'h2,
    SDC_CMD_ACT = 3'h3,
    SDC_CMD_WR  = 3'h4,
    SDC_CMD_RD  = 3'h5,
    SDC_CMD_BST = 3'h6,
    SDC_CMD_NOP = 3'h7
  } sdc_cmd_t;

  // Per-bank state, Gray coded along ACTIVE, RECOVER, PRECHG, IDLE
  typedef enum logic [1:0] {
    SDC_BK_IDLE    = 2'h0,
    SDC_BK_ACTIVE  = 2'h1,
    SDC_BK_RECOVER = 2'h3,
    SDC_BK_PRECHG  = 2'h2
  } sdc_bank_t;

endpackage
`default_nettype wire

// ### verilog/sdc_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty come straight from the fill count
`default_nettype none
module sdc_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;

  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;

  // Handshakes from the fill count
  assign in_ready_o  = (count != CW'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = store[rd_ptr];

  // Pointer wrap kept explicit so DEPTH need not be a power of two
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  // Storage has no reset
  always_ff @(posedge clk_i) begin
    if (push)
      store[wr_ptr] <= in_data_i;
  end

endmodule
`default_nettype wire

// ### verilog/sdc_device.sv
// Purpose: SDRAM core with concurrent auto precharge between banks
// Assumes: Pins resynchronised by two flops; one column burst engine
// Notes:   Array keeps one row per bank; row address is not stored
`include "sdc_regs.svh"
`default_nettype none

// Contract
// - A read to another bank stops an auto-precharge write burst at once.
// - Read data after such a cut appears one CAS latency after the read.
// - The cut write bank precharges only after write recovery from the read.
// - The last word written before a read cut is the one before the read.
// - A write to another bank stops an auto-precharge write burst at once.
// - The cut write bank precharges after write recovery from the new write.
// - Data given with the new write goes to the new bank, not the old one.
// - A high chip select makes the command a no-operation.
// - Column commands ignore address bits 8, 9 and 11 but sample bit 10.
// - A read cutting an auto-precharge read precharges that bank at once.
module sdc_device
  import sdc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Command and address pins
  input  wire logic        cs_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  ba_i,
  input  wire logic [11:0] addr_i,
  // Data pins, split into in, out and enable
  input  wire logic [1:0]  dqm_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic             dq_oe_o,
  // Status
  output logic             wbuf_ready_o,
  output logic      [3:0]  bank_idle_o
);
  localparam int PW = 36;

  // Burst length from mode code; single-write mode forces one word
  function automatic logic [8:0] sdc_len(input logic [2:0] code,
                                         input logic wbs, input logic wr);
    logic [8:0] len;
    len = 9'h001;
    if (!(wbs && wr)) begin
      unique case (code)
        3'h1:    len = 9'h002;
        3'h2:    len = 9'h004;
        3'h3:    len = 9'h008;
        3'h7:    len = 9'h100;
        default: len = 9'h001;
      endcase
    end
    return len;
  endfunction

  // Pin synchroniser, first stage read only by the second
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_s1 <= {1'b1, 3'h7, 32'h0};
      pin_s2 <= {1'b1, 3'h7, 32'h0};
    end else begin
      pin_s1 <= {cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i, dqm_i, dq_i};
      pin_s2 <= pin_s1;
    end
  end

  // Field extraction
  wire        s_cs_n = pin_s2[35];
  wire [2:0]  s_rcw  = pin_s2[34:32];
  wire [1:0]  s_ba   = pin_s2[31:30];
  wire [11:0] s_addr = pin_s2[29:18];
  wire [1:0]  s_dqm  = pin_s2[17:16];
  wire [15:0] s_dq   = pin_s2[15:0];

  // Command decode
  wire sdc_cmd_t cmd = s_cs_n ? SDC_CMD_NOP : sdc_cmd_t'(s_rcw);
  wire is_rd  = (cmd == SDC_CMD_RD);
  wire is_wr  = (cmd == SDC_CMD_WR);
  wire is_col = is_rd || is_wr;
  wire [7:0] s_col = s_addr[`SDC_COL_LSB +: `SDC_COL_W];
  wire       s_ap  = s_addr[`SDC_AP_BIT];

  // Mode register
  logic       cl3;
  logic [2:0] bl_code;
  logic       wbs;

  // Burst engine
  logic       bu_act;
  logic       bu_wr;
  logic       bu_ap;
  logic       bu_page;
  logic [1:0] bu_bank;
  logic [7:0] bu_col;
  logic [8:0] bu_left;

  // Bank state
  sdc_bank_t  bk_st  [0:3];
  sdc_bank_t  next_st [0:3];
  logic [7:0] bk_tmr [0:3];
  logic [7:0] next_tmr [0:3];

  // New burst length and burst continuation
  wire [8:0] new_len  = sdc_len(bl_code, wbs, is_wr);
  wire       new_page = (new_len == 9'h100);
  wire       cont     = bu_act && !is_col && (cmd != SDC_CMD_BST);
  wire       last_w   = cont && !bu_page && (bu_left == 9'h001);
  // A column command to any bank cuts the running burst
  wire       cut      = bu_act && is_col;

  // Auto-precharge events; two different banks can end together
  wire       ev_old   = (cut || last_w) && bu_ap;
  wire       ev_new   = is_col && s_ap && (new_len == 9'h001);

  // Column issue for this edge; a read edge writes nothing
  wire       wr_issue = is_wr || (cont && bu_wr);
  wire       rd_issue = is_rd || (cont && !bu_wr);
  wire [1:0] iss_bank = is_col ? s_ba : bu_bank;
  wire [7:0] iss_col  = is_col ? s_col : bu_col;

  // Write buffer between the pins and the array
  logic        wf_valid;
  logic [27:0] wf_data;
  logic        wf_ready;
  wire         wf_push = wr_issue && (s_dqm != 2'h3);

  sdc_fifo #(
    .WIDTH (`SDC_FIFO_W),
    .DEPTH (`SDC_FIFO_DEPTH)
  ) u_wbuf (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (wf_push),
    .in_data_i   ({s_dqm, iss_bank, iss_col, s_dq}),
    .in_ready_o  (wbuf_ready_o),
    .out_valid_o (wf_valid),
    .out_data_o  (wf_data),
    .out_ready_i (wf_ready)
  );

  // Mode register load only while no burst runs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cl3     <= 1'b0;
      bl_code <= `SDC_BL_RST;
      wbs     <= 1'b0;
    end else if (cmd == SDC_CMD_MRS && !bu_act) begin
      cl3     <= (s_addr[`SDC_CL_LSB +: 3] == 3'h3);
      bl_code <= s_addr[`SDC_BL_LSB +: 3];
      wbs     <= s_addr[`SDC_WBS_BIT];
    end
  end

  // Burst engine: a new column command always replaces the old burst
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bu_act  <= 1'b0;
      bu_wr   <= 1'b0;
      bu_ap   <= 1'b0;
      bu_page <= 1'b0;
      bu_bank <= 2'h0;
      bu_col  <= 8'h00;
      bu_left <= 9'h000;
    end else if (is_col) begin
      bu_act  <= (new_len != 9'h001);
      bu_wr   <= is_wr;
      bu_ap   <= s_ap && !new_page;
      bu_page <= new_page;
      bu_bank <= s_ba;
      bu_col  <= s_col + 8'h01;
      bu_left <= new_len - 9'h001;
    end else if (cont) begin
      bu_act  <= bu_page || (bu_left != 9'h001);
      bu_col  <= bu_col + 8'h01;
      bu_left <= bu_left - 9'h001;
    end else if (cmd == SDC_CMD_BST) begin
      bu_act  <= 1'b0;
    end
  end

  // Bank next state; recovery counts from the cutting edge
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      next_st[b]  = bk_st[b];
      next_tmr[b] = (bk_tmr[b] != 8'h00) ? bk_tmr[b] - 8'h01 : 8'h00;
      if (ev_old && bu_bank == 2'(b)) begin
        // Write waits for recovery, read precharges now
        next_st[b]  = bu_wr ? SDC_BK_RECOVER : SDC_BK_PRECHG;
        next_tmr[b] = bu_wr ? 8'(`SDC_TWR_CYC) : 8'(`SDC_TRP_CYC);
      end else if (ev_new && s_ba == 2'(b)) begin
        next_st[b]  = is_wr ? SDC_BK_RECOVER : SDC_BK_PRECHG;
        next_tmr[b] = is_wr ? 8'(`SDC_TWR_CYC) : 8'(`SDC_TRP_CYC);
      end else begin
        unique case (bk_st[b])
          SDC_BK_IDLE: begin
            if (cmd == SDC_CMD_ACT && s_ba == 2'(b))
              next_st[b] = SDC_BK_ACTIVE;
          end
          SDC_BK_ACTIVE: begin
            if (cmd == SDC_CMD_PRE &&
                (s_addr[`SDC_AP_BIT] || s_ba == 2'(b))) begin
              next_st[b]  = SDC_BK_PRECHG;
              next_tmr[b] = 8'(`SDC_TRP_CYC);
            end
          end
          SDC_BK_RECOVER: begin
            if (bk_tmr[b] == 8'h01) begin
              next_st[b]  = SDC_BK_PRECHG;
              next_tmr[b] = 8'(`SDC_TRP_CYC);
            end
          end
          SDC_BK_PRECHG: begin
            if (bk_tmr[b] == 8'h01)
              next_st[b] = SDC_BK_IDLE;
          end
        endcase
      end
    end
  end

  // Bank state registers
  always_ff @(posedge clk_i) begin
    for (int b = 0; b < 4; b++) begin
      bk_st[b]  <= reset_i ? SDC_BK_IDLE : next_st[b];
      bk_tmr[b] <= reset_i ? 8'h00 : next_tmr[b];
    end
  end

  // Idle flags for each bank
  assign bank_idle_o = {bk_st[3] == SDC_BK_IDLE, bk_st[2] == SDC_BK_IDLE,
                        bk_st[1] == SDC_BK_IDLE, bk_st[0] == SDC_BK_IDLE};

  // Read pipeline; a write kills words still in flight
  logic       rq1_v;
  logic       rq2_v;
  logic [9:0] rq1_a;
  logic [9:0] rq2_a;
  wire        sel_v = cl3 ? rq2_v : rq1_v;
  wire  [9:0] sel_a = cl3 ? rq2_a : rq1_a;
  wire        fetch = sel_v && !is_wr;

  always_ff @(posedge clk_i) begin
    if (reset_i || is_wr) begin
      rq1_v <= 1'b0;
      rq2_v <= 1'b0;
    end else begin
      rq1_v <= rd_issue;
      rq2_v <= rq1_v;
    end
    rq1_a <= {iss_bank, iss_col};
    rq2_a <= rq1_a;
  end

  // Array: reads have the port, buffered writes wait
  logic [15:0] mem [0:1023];
  assign wf_ready = !fetch;

  always_ff @(posedge clk_i) begin
    if (wf_valid && wf_ready) begin
      if (!wf_data[26])
        mem[wf_data[25:16]][7:0] <= wf_data[7:0];
      if (!wf_data[27])
        mem[wf_data[25:16]][15:8] <= wf_data[15:8];
    end
  end

  // Output stage, driven one edge before the latency edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dq_o    <= 16'h0000;
      dq_oe_o <= 1'b0;
    end else begin
      dq_oe_o <= fetch;
      if (fetch)
        dq_o <= mem[sel_a];
    end
  end

endmodule
`default_nettype wire

// ### bench/sdc_chk.sv
// Purpose: Port-level checks for the SDRAM core
// Assumes: Two sync flops ahead of every pin
// Notes:   Quiet check does not hold for full-page bursts
`default_nettype none
module sdc_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  // Command pins
  input wire logic        cs_n_i,
  input wire logic        ras_n_i,
  input wire logic        cas_n_i,
  input wire logic        we_n_i,
  input wire logic [1:0]  ba_i,
  // Outputs watched
  input wire logic        dq_oe_o,
  input wire logic [15:0] dq_o,
  input wire logic        wbuf_ready_o,
  input wire logic [3:0]  bank_idle_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Command decode as sampled on the pins
  wire logic [2:0] cmd = {ras_n_i, cas_n_i, we_n_i};
  wire logic rd  = !cs_n_i && cmd == 3'h5;
  wire logic wr  = !cs_n_i && cmd == 3'h4;
  wire logic act = !cs_n_i && cmd == 3'h3;
  wire logic col = rd || wr;
  logic [4:0] col_age;
  logic [4:0] rd_age;
  logic [4:0] wr_age;
  // Saturating ages, so old history cannot wrap into a false match
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      col_age <= 5'h1F;
      rd_age  <= 5'h1F;
      wr_age  <= 5'h1F;
    end else begin
      col_age <= col ? 5'h00 : col_age + {4'h0, col_age != 5'h1F};
      rd_age  <= rd ? 5'h00 : rd_age + {4'h0, rd_age != 5'h1F};
      wr_age  <= wr ? 5'h00 : wr_age + {4'h0, wr_age != 5'h1F};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_rst_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    reset_i |=> !dq_oe_o && dq_o == 16'h0000) else $error("bus after reset");
  a_rst_banks: assert property (@(posedge clk_i) disable iff (1'b0)
    reset_i |=> bank_idle_o == 4'hF && wbuf_ready_o)
    else $error("banks after reset");
  a_rd_answer: assert property (rd ##1 !col [*3] |-> ##[0:2] dq_oe_o)
    else $error("read gave no data");
  a_oe_cause: assert property ($rose(dq_oe_o) |-> rd_age <= 5'h06)
    else $error("data without read");
  a_nop_ignored: assert property (col_age >= 5'h10 |-> !dq_oe_o)
    else $error("deselected command acted");
  a_idle_late: assert property (
    $rose(bank_idle_o[0]) |-> wr_age >= 5'h06)
    else $error("precharge before recovery");
  a_act_busy: assert property (
    act && ba_i == 2'h0 |-> ##[2:4] !bank_idle_o[0])
    else $error("bank stayed idle");
  a_wbuf_drain: assert property (wr_age >= 5'h18 |-> wbuf_ready_o)
    else $error("buffer never drained");
  // Main scenarios reached
  c_read: cover property (rd ##[2:5] dq_oe_o);
  c_cut: cover property (wr ##[1:3] rd);
  c_idle: cover property ($rose(bank_idle_o[0]));
  c_rd_cut: cover property (rd ##1 rd);
endmodule
bind sdc_device sdc_chk u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
  .ba_i(ba_i), .dq_oe_o(dq_oe_o), .dq_o(dq_o),
  .wbuf_ready_o(wbuf_ready_o), .bank_idle_o(bank_idle_o));
`default_nettype wire

// ### bench/sdc_ctl.sv
// Purpose: Memory controller model driving the core's pins
// Assumes: Pins change just after the rising edge
// Notes:   Released data lines invert their previous value each slot
`default_nettype none
module sdc_ctl
  import sdc_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Pins toward the core
  output logic             cs_n_o,
  output sdc_cmd_t         cmd_o,
  output logic      [1:0]  ba_o,
  output logic      [11:0] addr_o,
  output logic      [1:0]  dqm_o,
  output logic      [15:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Deselected and masked at time zero
  initial begin
    cs_n_o = 1'b1;
    cmd_o  = SDC_CMD_NOP;
    ba_o   = 2'h0;
    addr_o = 12'h000;
    dqm_o  = 2'h3;
    dq_o   = 16'h0000;
  end
  // One command slot per clock
  task automatic put(input logic cs, input sdc_cmd_t c, input logic [1:0] b,
                     input logic [11:0] a, input logic dv,
                     input logic [15:0] d);
    @(posedge clk_i);
    cs_n_o <= cs;
    cmd_o  <= c;
    ba_o   <= b;
    addr_o <= a;
    dq_o   <= dv ? d : ~dq_o;
    dqm_o  <= dv ? 2'h0 : 2'h3; // Mask whenever no write word
    #1;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Concurrent auto-precharge scenarios for the SDRAM core
// Assumes: Burst length 4, CAS latency 2 unless stated
// Notes:   Reset held two edges; pins stay deselected meanwhile
`default_nettype none
module tb_top
  import sdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        cs_n;
  sdc_cmd_t    cmd;
  logic [1:0]  ba;
  logic [1:0]  dqm;
  logic [11:0] addr;
  logic [15:0] dq_w;
  logic [15:0] dq_r;
  logic        oe;
  logic        wrdy;
  logic [3:0]  idle;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          lat2;
  int          lat3;
  // Assumed row-active wait in cycles before a plain precharge
  localparam int RAS_GAP = 6;
  initial forever #4 clk_i = ~clk_i;
  sdc_ctl u_ctl (.clk_i(clk_i), .cs_n_o(cs_n), .cmd_o(cmd), .ba_o(ba),
    .addr_o(addr), .dqm_o(dqm), .dq_o(dq_w));
  sdc_device u_dut (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n),
    .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i(ba),
    .addr_i(addr), .dqm_i(dqm), .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(oe),
    .wbuf_ready_o(wrdy), .bank_idle_o(idle));
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic hang;
    n_fail++;
    give_verdict;
  endtask
  task automatic nop(input int n);
    repeat (n) u_ctl.put(1'b0, SDC_CMD_NOP, 2'h0, 12'h000, 1'b0, 16'h0);
  endtask
  // Write burst: command beat plus n-1 data beats, pattern base+i
  task automatic burst(input logic [1:0] b, input logic [7:0] c,
                       input logic ap, input int n, input logic [15:0] base);
    u_ctl.put(1'b0, SDC_CMD_WR, b, {1'b0, ap, 2'h0, c}, 1'b1, base);
    for (int i = 1; i < n; i++)
      u_ctl.put(1'b0, SDC_CMD_NOP, 2'h0, 12'h000, 1'b1, base + 16'(i));
  endtask
  // Read four words, word 0 in the low lane of e; cycles to data in lat
  task automatic rd_chk(input logic [1:0] b, input logic [11:0] a,
                        input logic [63:0] e, output int lat);
    u_ctl.put(1'b0, SDC_CMD_RD, b, a, 1'b0, 16'h0);
    lat = 0;
    while (oe !== 1'b1) begin
      if (lat == 10) hang;
      nop(1);
      lat++;
    end
    for (int i = 0; i < 4; i++) begin
      check(dq_r, e[16*i +: 16]);
      nop(1);
    end
  endtask
  // Bounded wait for a bank to finish recovery and precharge
  task automatic wait_idle(input int b);
    for (int k = 0; idle[b] !== 1'b1; k++) begin
      if (k == 30) hang;
      nop(1);
    end
  endtask
  task automatic deselect_test;
    u_ctl.put(1'b1, SDC_CMD_WR, 2'h1, 12'h000, 1'b1, 16'hEE);
    u_ctl.put(1'b1, SDC_CMD_ACT, 2'h2, 12'h000, 1'b0, 16'h0);
    u_ctl.put(1'b1, SDC_CMD_RD, 2'h1, 12'h000, 1'b0, 16'h0);
    nop(4);
    check({15'h0, oe}, 16'h0);
    nop(6);
    check({15'h0, idle[2]}, 16'h1);
  endtask
  // Plain write, row-active wait kept, then a one-bank precharge
  task automatic precharge_test;
    u_ctl.put(1'b0, SDC_CMD_ACT, 2'h2, 12'h000, 1'b0, 16'h0);
    burst(2'h2, 8'h10, 1'b0, 4, 16'hE0);
    nop(RAS_GAP);
    u_ctl.put(1'b0, SDC_CMD_PRE, 2'h2, 12'h000, 1'b0, 16'h0);
    nop(5);
    check({15'h0, idle[2]}, 16'h0);
    nop(1);
    check({15'h0, idle[2]}, 16'h1);
    u_ctl.put(1'b0, SDC_CMD_ACT, 2'h2, 12'h000, 1'b0, 16'h0);
    nop(3);
    rd_chk(2'h2, 12'h010, 64'h00E3_00E2_00E1_00E0, lat2);
  endtask
  task automatic cut_by_read;
    burst(2'h0, 8'h00, 1'b1, 3, 16'hB0);
    rd_chk(2'h1, 12'h000, 64'h00A3_00A2_00A1_00A0, lat2);
    wait_idle(0);
    u_ctl.put(1'b0, SDC_CMD_ACT, 2'h0, 12'h000, 1'b0, 16'h0);
    nop(3);
    rd_chk(2'h0, 12'h000, 64'h0003_00B2_00B1_00B0, lat3);
  endtask
  task automatic cut_by_write;
    burst(2'h0, 8'h04, 1'b1, 2, 16'hC0);
    burst(2'h1, 8'h04, 1'b0, 4, 16'hD0);
    wait_idle(0);
    u_ctl.put(1'b0, SDC_CMD_ACT, 2'h0, 12'h000, 1'b0, 16'h0);
    nop(8);
    rd_chk(2'h0, 12'h004, 64'h0007_0006_00C1_00C0, lat3);
    rd_chk(2'h1, 12'h004, 64'h00D3_00D2_00D1_00D0, lat3);
  endtask
  // Auto-precharge read cut one beat later; old bank precharges at the cut
  task automatic read_cut_test;
    u_ctl.put(1'b0, SDC_CMD_RD, 2'h0, 12'h400, 1'b0, 16'h0);
    u_ctl.put(1'b0, SDC_CMD_RD, 2'h1, 12'h000, 1'b0, 16'h0);
    nop(3);
    check(dq_r, 16'h00B0);
    for (int i = 0; i < 4; i++) begin
      nop(1);
      check(dq_r, 16'h00A0 + 16'(i));
      check({15'h0, idle[0]}, 16'(i > 1));
    end
  endtask
  // Longer latency, with the don't-care address bits all set
  task automatic latency_test;
    u_ctl.put(1'b0, SDC_CMD_MRS, 2'h0, 12'h032, 1'b0, 16'h0);
    nop(3);
    rd_chk(2'h1, 12'hB00, 64'h00A3_00A2_00A1_00A0, lat3);
    check(16'(lat3 - lat2), 16'h0001);
  endtask
  // Main sequence: mode load comes before any activate
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    u_ctl.put(1'b0, SDC_CMD_MRS, 2'h0, 12'h022, 1'b0, 16'h0);
    u_ctl.put(1'b0, SDC_CMD_ACT, 2'h0, 12'h000, 1'b0, 16'h0);
    u_ctl.put(1'b0, SDC_CMD_ACT, 2'h1, 12'h000, 1'b0, 16'h0);
    nop(2);
    burst(2'h0, 8'h00, 1'b0, 4, 16'h0);
    burst(2'h0, 8'h04, 1'b0, 4, 16'h4);
    burst(2'h1, 8'h00, 1'b0, 4, 16'hA0);
    nop(12);
    deselect_test;
    precharge_test;
    cut_by_read;
    cut_by_write;
    read_cut_test;
    latency_test;
    give_verdict;
  end
endmodule
`default_nettype wire
